// ==== cpu_regs_pkg.sv ====
// package: register ids, sizes, flag layout and reset values of the cpu register set
package cpu_regs_pkg;

	// ==========================================================
	// register ids, also the word index on the register bus
	typedef enum logic [4:0] {
		ID_DATA0 = 5'h00,
		ID_DATA1 = 5'h01,
		ID_DATA2 = 5'h02,
		ID_DATA3 = 5'h03,
		ID_ADDR0 = 5'h04,
		ID_ADDR1 = 5'h05,
		ID_FRAME = 5'h06,
		ID_VTB = 5'h07,
		ID_PC = 5'h08,
		ID_USP = 5'h09,
		ID_ISP = 5'h0A,
		ID_SB = 5'h0B,
		ID_FLAGS = 5'h0C,
		ID_ACTIVE_SP = 5'h0D,
		ID_DPAIR_LO = 5'h0E,
		ID_DPAIR_HI = 5'h0F,
		ID_APAIR = 5'h10
	} reg_id_t;

	// ==========================================================
	// access sizes of the core port and the alu
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} size_t;

	// ==========================================================
	// banked register slots
	localparam int GPR_CNT = 7;
	localparam int IX_D0 = 0;
	localparam int IX_D1 = 1;
	localparam int IX_D2 = 2;
	localparam int IX_D3 = 3;
	localparam int IX_A0 = 4;
	localparam int IX_A1 = 5;
	localparam int ADDR_LSB = 2;

	// ==========================================================
	// flag register layout
	localparam int FLG_C = 0;
	localparam int FLG_D = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_S = 3;
	localparam int FLG_B = 4;
	localparam int FLG_O = 5;
	localparam int FLG_I = 6;
	localparam int FLG_U = 7;
	localparam int IPL_LSB = 12;
	localparam int IPL_MSB = 14;
	localparam logic [15:0] FLG_MASK = 16'h70FF;
	localparam logic [5:0] SWI_U_MAX = 6'h1F;

	// ==========================================================
	// reset values and byte enables
	localparam logic [15:0] RST16 = 16'h0000;
	localparam logic [19:0] RST20 = 20'h0_0000;
	localparam logic [3:0] BE_LO = 4'h1;
	localparam logic [3:0] BE_HI = 4'h2;
	localparam logic [3:0] BE_WORD = 4'h3;
	localparam logic [3:0] BE_LONG = 4'hF;

endpackage: cpu_regs_pkg

// ==== flag_unit.sv ====
// flag update and interrupt acceptance logic of the cpu register set
`timescale 1ns/1ps
`default_nettype none

module flag_unit import cpu_regs_pkg::*; (
	input wire logic [15:0] cur, // flags now held
	input wire logic [15:0] base, // flags after a direct write
	input wire logic alu_valid, // alu result present
	input wire logic [1:0] alu_size, // alu operand size
	input wire logic [31:0] alu_result, // alu result
	input wire logic alu_carry, // carry, borrow or shift-out
	input wire logic alu_overflow, // overflow of operation
	input wire logic hw_ack, // hardware interrupt taken
	input wire logic swi_exec, // software interrupt executed
	input wire logic [5:0] swi_num, // software interrupt number
	input wire logic irq_req, // maskable request present
	input wire logic [2:0] irq_level, // level of request
	output logic [15:0] next_flags, // flags for next edge
	output logic irq_accept // request may be taken
);

	logic [31:0] res_mask;
	logic res_sign;

	// ==========================================================
	// result width
	always_comb begin
		res_mask = 32'hFFFF_FFFF;
		res_sign = alu_result[31];
		unique case (alu_size)
			SZ_BYTE: begin
				res_mask = 32'h0000_00FF;
				res_sign = alu_result[7];
			end
			SZ_WORD: begin
				res_mask = 32'h0000_FFFF;
				res_sign = alu_result[15];
			end
			SZ_LONG: begin
				res_mask = 32'hFFFF_FFFF;
				res_sign = alu_result[31];
			end
			default: begin
				res_mask = 32'hFFFF_FFFF;
				res_sign = alu_result[31];
			end
		endcase
	end

	// ==========================================================
	// flag events, applied over any direct write
	always_comb begin
		next_flags = base & FLG_MASK; // RL22
		if (alu_valid) begin
			next_flags[FLG_C] = alu_carry; // RL13
			next_flags[FLG_Z] = ((alu_result & res_mask) == 32'h0000_0000); // RL15
			next_flags[FLG_S] = res_sign; // RL16
			next_flags[FLG_O] = alu_overflow; // RL18
		end
		if (hw_ack) begin
			next_flags[FLG_I] = 1'h0; // RL19
			next_flags[FLG_U] = 1'h0; // RL20
		end
		if (swi_exec) begin
			next_flags[FLG_I] = 1'h0; // RL19
			if (swi_num <= SWI_U_MAX) begin
				next_flags[FLG_U] = 1'h0; // RL20
			end
		end
	end

	// maskable request taken only above the processor level
	assign irq_accept = irq_req && cur[FLG_I] && (irq_level > cur[IPL_MSB:IPL_LSB]); // RL19 RL21

endmodule: flag_unit

`default_nettype wire

// ==== cpu_core_register_set.sv ====
// cpu core register set with core ports and an avalon-mm slave
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RL1: four 16-bit data registers for transfer, arithmetic and logic.
// RL2: first two data registers split into independent high and low bytes.
// RL3: data 2 with data 0, data 3 with data 1 form 32-bit registers.
// RL4: two 16-bit address registers, also usable as general operands.
// RL5: address registers pair into one 32-bit register, second one high.
// RL6: 16-bit frame base register for frame-relative addressing.
// RL7: 20-bit vector table base register.
// RL8: 20-bit program counter.
// RL9: user and interrupt stack pointers, 16 bits; active one is stack pointer.
// RL10: stack select 0 picks interrupt pointer, 1 picks user pointer.
// RL11: 16-bit static base register.
// RL12: 11-bit flag register with flags and priority field.
// RL13: carry flag takes alu carry, borrow or shift-out.
// RL14: software keeps debug flag at 0.
// RL15: zero flag is 1 for zero result, else 0.
// RL16: sign flag is 1 for negative result, else 0.
// RL17: bank select flag picks register bank 0 or 1.
// RL18: overflow flag is 1 on overflow, else 0.
// RL19: interrupt enable gates maskable interrupts; cleared on acknowledge.
// RL20: stack select cleared on hardware interrupt or software interrupt 0 to 31.
// RL21: 3-bit priority level; request taken only when strictly above.
// RL22: reserved flag bits written as 0; reads need not be defined.
module cpu_core_register_set import cpu_regs_pkg::*; #(
	parameter int BANKS = 2 // register banks
) (
	input wire logic CLK, // core clock
	input wire logic RESETN, // sync reset, low active
	input wire logic CE, // clock enable
	input wire logic [6:0] AVS_ADDRESS, // byte address
	input wire logic AVS_READ, // bus read
	input wire logic AVS_WRITE, // bus write
	input wire logic [31:0] AVS_WRITEDATA, // bus write data
	input wire logic [3:0] AVS_BYTEENABLE, // bus byte lanes
	output logic [31:0] AVS_READDATA, // bus read data
	output logic AVS_WAITREQUEST, // bus stall
	input wire logic CORE_WE, // core write strobe
	input wire logic [4:0] CORE_SEL, // core write register
	input wire logic [1:0] CORE_SIZE, // core write size
	input wire logic CORE_HIGH, // byte write to high half
	input wire logic [31:0] CORE_WDATA, // core write data
	input wire logic [4:0] CORE_RSEL, // core read register
	output logic [31:0] CORE_RDATA, // core read data
	input wire logic ALU_VALID, // alu result present
	input wire logic [1:0] ALU_SIZE, // alu size
	input wire logic [31:0] ALU_RESULT, // alu result
	input wire logic ALU_CARRY, // alu carry out
	input wire logic ALU_OVERFLOW, // alu overflow
	input wire logic INT_HW_ACK, // hardware interrupt taken
	input wire logic SWI_EXEC, // software interrupt executed
	input wire logic [5:0] SWI_NUM, // software interrupt number
	input wire logic IRQ_REQ, // maskable request
	input wire logic [2:0] IRQ_LEVEL, // request priority
	output logic IRQ_ACCEPT, // request may be taken
	output logic [19:0] PC_OUT, // program counter
	output logic [19:0] VTB_OUT, // vector table base
	output logic [15:0] FLAGS_OUT // flag register
);

	// ==========================================================
	// elaboration check
	if (BANKS != 2) begin : g_bank_chk
		$error("BANKS must be 2");
	end

	// ==========================================================
	// storage
	logic [15:0] gpr [0:BANKS-1][0:GPR_CNT-1]; // RL1 RL4 RL6
	logic [19:0] vtb;
	logic [19:0] pc;
	logic [15:0] user_stack_pointer;
	logic [15:0] interrupt_stack_pointer;
	logic [15:0] sb;
	logic [15:0] flags;
	logic bank;

	logic bus_req;
	logic bus_ack;
	logic busy;
	logic bus_wr;
	reg_id_t bus_sel;

	logic w_en;
	reg_id_t w_sel;
	logic [3:0] w_be;
	logic [31:0] w_data;
	logic [31:0] w_val;
	logic [15:0] flag_base;
	logic [15:0] next_flags;

	assign bank = flags[FLG_B]; // RL17

	// ==========================================================
	// read view of any register id
	function automatic logic [31:0] fn_rd(input reg_id_t sel);
		unique case (sel)
			ID_DATA0, ID_DATA1, ID_DATA2, ID_DATA3, ID_ADDR0, ID_ADDR1, ID_FRAME: begin
				fn_rd = {16'h0000, gpr[bank][sel[2:0]]};
			end
			ID_VTB: fn_rd = {12'h000, vtb};
			ID_PC: fn_rd = {12'h000, pc};
			ID_USP: fn_rd = {16'h0000, user_stack_pointer};
			ID_ISP: fn_rd = {16'h0000, interrupt_stack_pointer};
			ID_SB: fn_rd = {16'h0000, sb};
			ID_FLAGS: fn_rd = {16'h0000, flags};
			ID_ACTIVE_SP: fn_rd = {16'h0000, flags[FLG_U] ? user_stack_pointer : interrupt_stack_pointer}; // RL9 RL10
			ID_DPAIR_LO: fn_rd = {gpr[bank][IX_D2], gpr[bank][IX_D0]}; // RL3
			ID_DPAIR_HI: fn_rd = {gpr[bank][IX_D3], gpr[bank][IX_D1]}; // RL3
			ID_APAIR: fn_rd = {gpr[bank][IX_A1], gpr[bank][IX_A0]}; // RL5
			default: fn_rd = 32'h0000_0000;
		endcase
	endfunction: fn_rd

	// byte-lane merge of new data over old
	function automatic logic [31:0] fn_merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			fn_merge[8*i +: 8] = be[i] ? d[8*i +: 8] : old[8*i +: 8];
		end
	endfunction: fn_merge

	// byte lanes of a core write
	function automatic logic [3:0] fn_core_be(input logic [1:0] size, input logic high);
		unique case (size)
			SZ_BYTE: fn_core_be = high ? BE_HI : BE_LO; // RL2
			SZ_WORD: fn_core_be = BE_WORD;
			SZ_LONG: fn_core_be = BE_LONG;
			default: fn_core_be = BE_WORD;
		endcase
	endfunction: fn_core_be

	// ==========================================================
	// avalon slave: one wait cycle, longer while the core updates
	assign bus_req = AVS_READ || AVS_WRITE;
	assign busy = CORE_WE || ALU_VALID || INT_HW_ACK || SWI_EXEC;
	assign bus_sel = reg_id_t'(AVS_ADDRESS[6:ADDR_LSB]);
	assign AVS_WAITREQUEST = bus_req && !(bus_ack && !busy && CE);
	assign bus_wr = AVS_WRITE && bus_ack && !busy;

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			bus_ack <= 1'h0;
		end else if (CE) begin
			bus_ack <= bus_req && !(bus_ack && !busy);
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (CE && bus_req) begin
			AVS_READDATA <= fn_rd(bus_sel);
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			CORE_RDATA <= 32'h0000_0000;
		end else if (CE) begin
			CORE_RDATA <= fn_rd(reg_id_t'(CORE_RSEL));
		end
	end

	// ==========================================================
	// single write path, core before bus
	always_comb begin
		w_en = 1'h0;
		w_sel = bus_sel;
		w_be = AVS_BYTEENABLE;
		w_data = AVS_WRITEDATA;
		if (CE && CORE_WE) begin
			w_en = 1'h1;
			w_sel = reg_id_t'(CORE_SEL);
			w_be = fn_core_be(CORE_SIZE, CORE_HIGH);
			if (CORE_SIZE == SZ_BYTE && CORE_HIGH) begin
				w_data = {CORE_WDATA[23:0], 8'h00}; // RL2
			end else begin
				w_data = CORE_WDATA;
			end
		end else if (CE && bus_wr) begin
			w_en = 1'h1;
		end
	end

	assign w_val = fn_merge(fn_rd(w_sel), w_data, w_be);

	// ==========================================================
	// banked data, address and frame base registers
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			for (int k = 0; k < BANKS; k++) begin
				for (int j = 0; j < GPR_CNT; j++) begin
					gpr[k][j] <= RST16;
				end
			end
		end else if (w_en) begin
			unique case (w_sel)
				ID_DATA0, ID_DATA1, ID_DATA2, ID_DATA3, ID_ADDR0, ID_ADDR1, ID_FRAME: begin
					gpr[bank][w_sel[2:0]] <= w_val[15:0]; // RL1 RL4 RL6 RL17
				end
				ID_DPAIR_LO: begin
					gpr[bank][IX_D0] <= w_val[15:0]; // RL3
					gpr[bank][IX_D2] <= w_val[31:16];
				end
				ID_DPAIR_HI: begin
					gpr[bank][IX_D1] <= w_val[15:0]; // RL3
					gpr[bank][IX_D3] <= w_val[31:16];
				end
				ID_APAIR: begin
					gpr[bank][IX_A0] <= w_val[15:0]; // RL5
					gpr[bank][IX_A1] <= w_val[31:16];
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// vector table base and program counter
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			vtb <= RST20;
		end else if (w_en && w_sel == ID_VTB) begin
			vtb <= w_val[19:0]; // RL7
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			pc <= RST20;
		end else if (w_en && w_sel == ID_PC) begin
			pc <= w_val[19:0]; // RL8
		end
	end

	// ==========================================================
	// stack pointers and static base
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			user_stack_pointer <= RST16;
		end else if (w_en && (w_sel == ID_USP || (w_sel == ID_ACTIVE_SP && flags[FLG_U]))) begin
			user_stack_pointer <= w_val[15:0]; // RL9 RL10
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			interrupt_stack_pointer <= RST16;
		end else if (w_en && (w_sel == ID_ISP || (w_sel == ID_ACTIVE_SP && !flags[FLG_U]))) begin
			interrupt_stack_pointer <= w_val[15:0]; // RL9 RL10
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			sb <= RST16;
		end else if (w_en && w_sel == ID_SB) begin
			sb <= w_val[15:0]; // RL11
		end
	end

	// ==========================================================
	// flag register
	assign flag_base = (w_en && w_sel == ID_FLAGS) ? w_val[15:0] : flags;

	flag_unit u_flags (
		.cur(flags),
		.base(flag_base),
		.alu_valid(ALU_VALID),
		.alu_size(ALU_SIZE),
		.alu_result(ALU_RESULT),
		.alu_carry(ALU_CARRY),
		.alu_overflow(ALU_OVERFLOW),
		.hw_ack(INT_HW_ACK),
		.swi_exec(SWI_EXEC),
		.swi_num(SWI_NUM),
		.irq_req(IRQ_REQ),
		.irq_level(IRQ_LEVEL),
		.next_flags(next_flags),
		.irq_accept(IRQ_ACCEPT)
	);

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			flags <= RST16;
		end else if (CE) begin
			flags <= next_flags; // RL12 RL22
		end
	end

	assign PC_OUT = pc;
	assign VTB_OUT = vtb;
	assign FLAGS_OUT = flags;

	// ==========================================================
	// assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	property p_byte_hi;
		CE && CORE_WE && CORE_SEL == ID_DATA1 && CORE_SIZE == SZ_BYTE && CORE_HIGH && !bank
		|=> gpr[0][IX_D1] == {$past(CORE_WDATA[7:0]), $past(gpr[0][IX_D1][7:0])};
	endproperty
	a_byte_hi: assert property (p_byte_hi) else $error("high byte write wrong"); // RL2

	property p_pair;
		CE && CORE_WE && CORE_SEL == ID_DPAIR_HI && CORE_SIZE == SZ_LONG
		|=> fn_rd(ID_DPAIR_HI) == $past(CORE_WDATA);
	endproperty
	a_pair: assert property (p_pair) else $error("data pair write wrong"); // RL3

	property p_sp;
		CE && CORE_RSEL == ID_ACTIVE_SP
		|=> CORE_RDATA[15:0] == ($past(flags[FLG_U]) ? $past(user_stack_pointer) : $past(interrupt_stack_pointer));
	endproperty
	a_sp: assert property (p_sp) else $error("active stack pointer wrong"); // RL10

	property p_carry;
		CE && ALU_VALID |=> flags[FLG_C] == $past(ALU_CARRY);
	endproperty
	a_carry: assert property (p_carry) else $error("carry flag wrong"); // RL13

	property p_zero;
		CE && ALU_VALID && ALU_SIZE == SZ_WORD
		|=> flags[FLG_Z] == ($past(ALU_RESULT[15:0]) == 16'h0000);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong"); // RL15

	property p_sign;
		CE && ALU_VALID && ALU_SIZE == SZ_BYTE |=> flags[FLG_S] == $past(ALU_RESULT[7]);
	endproperty
	a_sign: assert property (p_sign) else $error("sign flag wrong"); // RL16

	property p_bank;
		w_en && w_sel == ID_DATA0 && bank |=> $stable(gpr[0][IX_D0]);
	endproperty
	a_bank: assert property (p_bank) else $error("bank 0 written in bank 1"); // RL17

	property p_ovf;
		CE && ALU_VALID |=> flags[FLG_O] == $past(ALU_OVERFLOW);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag wrong"); // RL18

	property p_ack_i;
		CE && (INT_HW_ACK || SWI_EXEC) |=> !flags[FLG_I];
	endproperty
	a_ack_i: assert property (p_ack_i) else $error("enable flag not cleared"); // RL19

	property p_ack_u;
		CE && (INT_HW_ACK || (SWI_EXEC && SWI_NUM <= SWI_U_MAX)) |=> !flags[FLG_U];
	endproperty
	a_ack_u: assert property (p_ack_u) else $error("stack select not cleared"); // RL20

	property p_irq;
		IRQ_ACCEPT |-> IRQ_REQ && flags[FLG_I] && IRQ_LEVEL > flags[IPL_MSB:IPL_LSB];
	endproperty
	a_irq: assert property (p_irq) else $error("request taken at low level"); // RL21

endmodule: cpu_core_register_set

`default_nettype wire

// ==== tb_top.sv ====
// self-checking testbench of the cpu core register set
`timescale 1ns/1ps
`default_nettype none

module tb_top import cpu_regs_pkg::*; ;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic CE = 1'b1;
	logic [6:0] AVS_ADDRESS = 7'h00;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
	logic [3:0] AVS_BYTEENABLE = 4'h0;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic CORE_WE = 1'b0;
	logic [4:0] CORE_SEL = 5'h00;
	logic [1:0] CORE_SIZE = 2'h0;
	logic CORE_HIGH = 1'b0;
	logic [31:0] CORE_WDATA = 32'h0000_0000;
	logic [4:0] CORE_RSEL = ID_DPAIR_HI;
	logic [31:0] CORE_RDATA;
	logic ALU_VALID = 1'b0;
	logic [1:0] ALU_SIZE = 2'h0;
	logic [31:0] ALU_RESULT = 32'h0000_0000;
	logic ALU_CARRY = 1'b0;
	logic ALU_OVERFLOW = 1'b0;
	logic INT_HW_ACK = 1'b0;
	logic SWI_EXEC = 1'b0;
	logic [5:0] SWI_NUM = 6'h00;
	logic IRQ_REQ = 1'b0;
	logic [2:0] IRQ_LEVEL = 3'h0;
	logic IRQ_ACCEPT;
	logic [19:0] PC_OUT;
	logic [19:0] VTB_OUT;
	logic [15:0] FLAGS_OUT;
	int errors = 0;
	int num_checks = 0;

	always #25 CLK = ~CLK;

	cpu_core_register_set #(.BANKS(2)) dut (
		.CLK, .RESETN, .CE, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
		.AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .CORE_WE, .CORE_SEL,
		.CORE_SIZE, .CORE_HIGH, .CORE_WDATA, .CORE_RSEL, .CORE_RDATA, .ALU_VALID,
		.ALU_SIZE, .ALU_RESULT, .ALU_CARRY, .ALU_OVERFLOW, .INT_HW_ACK, .SWI_EXEC,
		.SWI_NUM, .IRQ_REQ, .IRQ_LEVEL, .IRQ_ACCEPT, .PC_OUT, .VTB_OUT, .FLAGS_OUT
	);

	// ==========================================================
	// reporting
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask: check

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask: give_verdict

	// ==========================================================
	// expectations
	function automatic logic [31:0] wmask(input int id);
		if (id == 7 || id == 8) return 32'h000F_FFFF;
		if (id <= 13) return 32'h0000_FFFF;
		if (id <= 16) return 32'hFFFF_FFFF;
		return 32'h0000_0000;
	endfunction: wmask

	function automatic logic [15:0] alu_exp(input logic [15:0] f, input logic [1:0] sz,
			input logic [31:0] r, input logic c, input logic o);
		logic [31:0] m;
		m = (sz == SZ_BYTE) ? 32'h0000_00FF : (sz == SZ_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
		f[FLG_C] = c;
		f[FLG_Z] = ((r & m) == 32'h0000_0000);
		f[FLG_S] = (sz == SZ_BYTE) ? r[7] : (sz == SZ_WORD) ? r[15] : r[31];
		f[FLG_O] = o;
		return f;
	endfunction: alu_exp

	// ==========================================================
	// bus and core drivers
	task automatic bus(input logic wr, input logic [4:0] id, input logic [31:0] wd,
			input logic [3:0] be, input int stall, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge CLK);
		AVS_ADDRESS <= {id, 2'b00};
		AVS_READ <= !wr;
		AVS_WRITE <= wr;
		AVS_WRITEDATA <= wd;
		AVS_BYTEENABLE <= be;
		CE <= (stall == 0);
		repeat (stall) begin
			@(negedge CLK);
			check("stalled waitrequest", {31'h0, AVS_WAITREQUEST}, 32'h0000_0001);
		end
		if (stall > 0) begin
			@(posedge CLK);
			CE <= 1'b1;
		end
		do begin
			@(posedge CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
		rd = AVS_READDATA;
		if (AVS_WAITREQUEST !== 1'b0) begin
			errors++;
			$display("unexpected bus answer: expected ready, seen stall");
			give_verdict();
		end
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask: bus

	task automatic wr(input logic [4:0] id, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] x;
		bus(1'b1, id, d, be, 0, x);
	endtask: wr

	task automatic rdc(input string what, input logic [4:0] id, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, id, 32'h0000_0000, BE_LONG, 0, v);
		check(what, v, exp);
	endtask: rdc

	task automatic core(input logic [4:0] id, input logic [1:0] sz, input logic hi,
			input logic [31:0] d);
		@(posedge CLK);
		CORE_WE <= 1'b1;
		CORE_SEL <= id;
		CORE_SIZE <= sz;
		CORE_HIGH <= hi;
		CORE_WDATA <= d;
		@(posedge CLK);
		CORE_WE <= 1'b0;
	endtask: core

	task automatic event_pulse(input logic hw, input logic [5:0] num);
		@(posedge CLK);
		INT_HW_ACK <= hw;
		SWI_EXEC <= !hw;
		SWI_NUM <= num;
		@(posedge CLK);
		INT_HW_ACK <= 1'b0;
		SWI_EXEC <= 1'b0;
		@(negedge CLK);
	endtask: event_pulse

	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] r;
		logic [4:0] id;
		logic [15:0] ef;
		logic [1:0] sz;
		logic c;
		logic o;
		void'($urandom(30));
		repeat (20) @(posedge CLK);
		RESETN <= 1'b1;
		for (int i = 0; i <= 16; i++) begin
			rdc("reset value", 5'(i), 32'h0000_0000);
		end
		check("pc after reset", {12'h0, PC_OUT}, 32'h0000_0000);
		$display("test reset values done");
		for (int k = 0; k < 40; k++) begin
			id = 5'($urandom_range(11));
			r = $urandom();
			wr(id, r, BE_LONG);
			rdc("random register", id, r & wmask(id));
		end
		wr(5'd20, 32'hFFFF_FFFF, BE_LONG);
		rdc("unmapped read", 5'd20, 32'h0000_0000);
		wr(ID_PC, 32'hFFFF_FFFF, BE_LONG);
		wr(ID_VTB, 32'h000A_5A5A, BE_LONG);
		@(negedge CLK);
		check("pc out", {12'h0, PC_OUT}, 32'h000F_FFFF);
		check("vector base out", {12'h0, VTB_OUT}, 32'h000A_5A5A);
		$display("test register widths done");
		wr(ID_DATA0, 32'h0000_1234, BE_WORD);
		wr(ID_DATA0, 32'h0000_AB00, BE_HI);
		rdc("data0 high byte", ID_DATA0, 32'h0000_AB34);
		wr(ID_DATA0, 32'h0000_00CD, BE_LO);
		rdc("data0 low byte", ID_DATA0, 32'h0000_ABCD);
		wr(ID_DATA1, 32'h0000_1234, BE_WORD);
		core(ID_DATA1, SZ_BYTE, 1'b1, 32'h0000_0056);
		rdc("data1 core high byte", ID_DATA1, 32'h0000_5634);
		core(ID_DATA1, SZ_BYTE, 1'b0, 32'h0000_0078);
		rdc("data1 core low byte", ID_DATA1, 32'h0000_5678);
		$display("test byte halves done");
		wr(ID_DPAIR_LO, 32'hAAAA_5555, BE_LONG);
		rdc("pair low to data0", ID_DATA0, 32'h0000_5555);
		rdc("pair low to data2", ID_DATA2, 32'h0000_AAAA);
		core(ID_DPAIR_HI, SZ_LONG, 1'b0, 32'h1357_2468);
		rdc("pair high to data1", ID_DATA1, 32'h0000_2468);
		rdc("pair high to data3", ID_DATA3, 32'h0000_1357);
		check("core read of pair", CORE_RDATA, 32'h1357_2468);
		CORE_RSEL <= ID_ACTIVE_SP;
		wr(ID_APAIR, 32'hBEEF_CAFE, BE_LONG);
		rdc("addr pair to addr0", ID_ADDR0, 32'h0000_CAFE);
		rdc("addr pair to addr1", ID_ADDR1, 32'h0000_BEEF);
		rdc("addr pair", ID_APAIR, 32'hBEEF_CAFE);
		$display("test pairs done");
		wr(ID_USP, 32'h0000_1111, BE_LONG);
		wr(ID_ISP, 32'h0000_2222, BE_LONG);
		wr(ID_FLAGS, 32'h0000_0000, BE_LONG);
		rdc("active sp with u clear", ID_ACTIVE_SP, 32'h0000_2222);
		check("core active sp u clear", CORE_RDATA, 32'h0000_2222);
		wr(ID_FLAGS, 32'h0000_0080, BE_LONG);
		rdc("active sp with u set", ID_ACTIVE_SP, 32'h0000_1111);
		check("core active sp u set", CORE_RDATA, 32'h0000_1111);
		wr(ID_FLAGS, 32'h0000_0000, BE_LONG);
		wr(ID_DATA0, 32'h0000_0BAD, BE_WORD);
		wr(ID_FLAGS, 32'h0000_0010, BE_LONG);
		rdc("bank 1 data0", ID_DATA0, 32'h0000_0000);
		wr(ID_DATA0, 32'h0000_0ACE, BE_WORD);
		wr(ID_FLAGS, 32'h0000_70F5, BE_LONG);
		rdc("flags readback", ID_FLAGS, 32'h0000_70F5);
		wr(ID_FLAGS, 32'h0000_0000, BE_LONG);
		rdc("bank 0 data0", ID_DATA0, 32'h0000_0BAD);
		$display("test stack and bank select done");
		ef = 16'h0000;
		for (int k = 0; k < 24; k++) begin
			sz = 2'($urandom_range(2));
			r = $urandom();
			if (k % 3 == 0) begin
				r = r & 32'hFFFF_0000;
			end
			c = 1'($urandom());
			o = 1'($urandom());
			ef = alu_exp(ef, sz, r, c, o);
			@(posedge CLK);
			ALU_VALID <= 1'b1;
			ALU_SIZE <= sz;
			ALU_RESULT <= r;
			ALU_CARRY <= c;
			ALU_OVERFLOW <= o;
			@(posedge CLK);
			ALU_VALID <= 1'b0;
			@(negedge CLK);
			check("alu flags", {16'h0, FLAGS_OUT}, {16'h0, ef});
		end
		$display("test alu flags done");
		wr(ID_FLAGS, 32'h0000_30C0, BE_LONG);
		IRQ_REQ <= 1'b1;
		for (int l = 0; l < 8; l++) begin
			@(posedge CLK);
			IRQ_LEVEL <= 3'(l);
			@(negedge CLK);
			check("irq accept", {31'h0, IRQ_ACCEPT}, {31'h0, l > 3});
		end
		wr(ID_FLAGS, 32'h0000_3080, BE_LONG);
		@(negedge CLK);
		check("irq masked", {31'h0, IRQ_ACCEPT}, 32'h0000_0000);
		@(posedge CLK);
		IRQ_REQ <= 1'b0;
		wr(ID_FLAGS, 32'h0000_30C0, BE_LONG);
		event_pulse(1'b1, 6'h00);
		check("flags after hw ack", {16'h0, FLAGS_OUT}, 32'h0000_3000);
		wr(ID_FLAGS, 32'h0000_30C0, BE_LONG);
		event_pulse(1'b0, 6'h20);
		check("flags after swi 32", {16'h0, FLAGS_OUT}, 32'h0000_3080);
		event_pulse(1'b0, 6'h1F);
		check("flags after swi 31", {16'h0, FLAGS_OUT}, 32'h0000_3000);
		$display("test interrupt flags done");
		bus(1'b0, ID_FLAGS, 32'h0000_0000, BE_LONG, 4, r);
		check("flags read after stall", r, 32'h0000_3000);
		$display("test bus stall done");
		give_verdict();
	end
endmodule: tb_top

`default_nettype wire
